// [shared/supervisor_pkg.sv]
// constants and helpers shared by the output fault supervisor
//------------------------------------------------------------
// How it works
// - constant-voltage outputs flag low below 10%, led rail below 1%.
// - out of regulation for over 32 switching cycles means overload.
// - average pulse rate per output above limit for qualifying time faults.
// - four rate limits 30/41/56/78 kHz; pin a resistor code picks first, pin b resistor code the rail.
// - second output limit from capacitor presence on both limit pins.
// - qualifying time lets double power flow for at least 10 ms.
// - overvoltage on any output feedback is a restart or latch fault.
// - string asymmetry beyond threshold disables the shorter strings.
// - open or shorted strings are disabled; the rest keep running.
// - led return short forces restart; the string stays off afterwards.
// - over protect level: outputs off, rail held, resume below hysteresis.
// - over shutdown level: latch-off request at once.
// - overload, rate, ov, return short and shutdown faults give exactly one response: restart or latch-off.
// - auto-restart stops all requests; primary restarts after its timeout.
// - latch-off request; primary stays off until mains is cycled.
//------------------------------------------------------------
package supervisor_pkg;
    localparam int N_OUT = 3;
    localparam int N_STR = 4;
    // register offsets
    localparam logic [7:0] A_CTRL   = 8'h00;
    localparam logic [7:0] A_STATUS = 8'h04;
    localparam logic [7:0] A_MASK   = 8'h08;
    localparam logic [7:0] A_STATE  = 8'h0c;
    // status and mask bit positions
    localparam int S_UV  = 0;
    localparam int S_LIM = 1;
    localparam int S_OV  = 2;
    localparam int S_STR = 3;
    localparam int S_HOT = 4;
    localparam int S_SD  = 5;
    localparam int N_EV  = 6;
    localparam logic [N_EV-1:0] MASK_RST = 6'h00;
    localparam logic CTRL_RST = 1'b1;
    // comparator levels of the out-of-regulation flags, percent
    localparam int UV_PCT_CV  = 10;
    localparam int UV_PCT_LED = 1;
    localparam logic [5:0] UV_CYCLES = 6'h20;
    // rate limits in kHz, by 2-bit code
    localparam int LIM_KHZ0 = 30;
    localparam int LIM_KHZ1 = 41;
    localparam int LIM_KHZ2 = 56;
    localparam int LIM_KHZ3 = 78;
    // timing
    localparam int CLK_KHZ  = 10000;
    localparam int WIN_US   = 1000;
    localparam int QUAL_MS  = 10;
    localparam int WIN_DEF  = CLK_KHZ * WIN_US / 1000;
    localparam logic [3:0] QUAL_WINS = 4'(QUAL_MS * 1000 / WIN_US);
    localparam int RESTART_DEF = 10000;

    // pulses allowed in one window for a limit code
    function automatic logic [7:0] lim_count(input logic [1:0] code, input int win);
        int khz;
        khz = (code == 2'h0) ? LIM_KHZ0 : (code == 2'h1) ? LIM_KHZ1 :
              (code == 2'h2) ? LIM_KHZ2 : LIM_KHZ3;
        return 8'(khz * win / CLK_KHZ);
    endfunction : lim_count
endpackage : supervisor_pkg

// [logic/output_fault_supervisor.sv]
// output fault supervisor: overload, rate limit, ov, string and thermal faults
//
// Added by the designer: the strobed register port and the address map.
`timescale 1ns/100ps
module output_fault_supervisor
    import supervisor_pkg::*;
#(
    parameter int WIN_CYCLES     = WIN_DEF,
    parameter int RESTART_CYCLES = RESTART_DEF
) (
    input  wire logic              mclk_in,
    input  wire logic              nrst_in,
    input  wire logic              ce_in,
    input  wire logic [7:0]        addr_in,
    input  wire logic [31:0]       wdata_in,
    input  wire logic              wr_in,
    input  wire logic              rd_in,
    output logic      [31:0]       rdata_out,
    input  wire logic [N_OUT-1:0]  uv_in,
    input  wire logic [N_OUT-1:0]  ov_in,
    input  wire logic [N_OUT-1:0]  pulse_in,
    input  wire logic [N_STR-1:0]  str_open_in,
    input  wire logic [N_STR-1:0]  str_short_in,
    input  wire logic [N_STR-1:0]  str_asym_in,
    input  wire logic [N_STR-1:0]  ret_gnd_in,
    input  wire logic              temp_prot_in,
    input  wire logic              temp_cool_in,
    input  wire logic              temp_sd_in,
    input  wire logic [1:0]        limit_select_pin_a_res_in,
    input  wire logic [1:0]        limit_select_pin_b_res_in,
    input  wire logic              limit_select_pin_a_cap_in,
    input  wire logic              limit_select_pin_b_cap_in,
    input  wire logic [2:0]        latch_sel_in,
    output logic                   req_enable_out,
    output logic                   latch_off_out,
    output logic [N_STR-1:0]       string_off_out,
    output logic                   outputs_off_out,
    output logic                   rail_hold_out,
    output logic                   irq_out
);
    localparam int NP = 37;

    typedef enum logic [1:0] {ST_RUN, ST_RESTART, ST_LATCH} state_t;

    //------------------------------------------------------------
    // reset release
    //------------------------------------------------------------
    logic [1:0] rst_sync;
    logic       rst_n;

    // two-stage release of the asynchronous reset
    always_ff @(posedge mclk_in or negedge nrst_in) begin
        if (!nrst_in) rst_sync <= 2'h0;
        else          rst_sync <= {rst_sync[0], 1'b1};
    end
    assign rst_n = rst_sync[1];

    //------------------------------------------------------------
    // pin synchronisers
    //------------------------------------------------------------
    logic [NP-1:0] pin_raw;
    logic [NP-1:0] s1;
    logic [NP-1:0] s2;
    logic [NP-1:0] s3;
    logic [NP-1:0] pin_c;

    assign pin_raw = {latch_sel_in, limit_select_pin_b_cap_in,
                      limit_select_pin_a_cap_in, limit_select_pin_b_res_in,
                      limit_select_pin_a_res_in, temp_sd_in, temp_cool_in,
                      temp_prot_in, ret_gnd_in, str_asym_in, str_short_in,
                      str_open_in, pulse_in, ov_in, uv_in};

    // three stages; a level is taken once stages two and three agree
    always_ff @(posedge mclk_in or negedge rst_n) begin
        if (!rst_n) begin
            s1    <= '0;
            s2    <= '0;
            s3    <= '0;
            pin_c <= '0;
        end else if (ce_in) begin
            s1    <= pin_raw;
            s2    <= s1;
            s3    <= s2;
            pin_c <= (s2 & s3) | (pin_c & (s2 ^ s3));
        end
    end

    logic [2:0]       lsel;
    logic             cap_b;
    logic             cap_a;
    logic [1:0]       res_b;
    logic [1:0]       res_a;
    logic             t_sd;
    logic             t_cool;
    logic             thermal_protect_level;
    logic [N_STR-1:0] ret_c;
    logic [N_STR-1:0] asym_c;
    logic [N_STR-1:0] short_c;
    logic [N_STR-1:0] open_c;
    logic [N_OUT-1:0] pulse_c;
    logic [N_OUT-1:0] ov_c;
    logic [N_OUT-1:0] uv_c;

    assign {lsel, cap_b, cap_a, res_b, res_a, t_sd, t_cool, thermal_protect_level, ret_c,
            asym_c, short_c, open_c, pulse_c, ov_c, uv_c} = pin_c;

    //------------------------------------------------------------
    // control state and register file
    //------------------------------------------------------------
    state_t           state;
    state_t           next_state;
    logic             hot;
    logic             en;
    logic [N_EV-1:0]  status;
    logic [N_EV-1:0]  next_status;
    logic [N_EV-1:0]  mask;
    logic [N_EV-1:0]  ev;
    logic             run;
    logic             clr;

    assign run = (state == ST_RUN) && !hot;
    assign clr = !run || !en; // restart, latch-off, thermal hold or a cleared enable empties counters

    //------------------------------------------------------------
    // switching cycle edges
    //------------------------------------------------------------
    logic [N_OUT-1:0] pulse_d;
    logic [N_OUT-1:0] pulse_e;
    logic             cyc;

    // edge detect on the clean pulse lines
    always_ff @(posedge mclk_in or negedge rst_n) begin
        if (!rst_n)     pulse_d <= '0;
        else if (ce_in) pulse_d <= pulse_c;
    end
    assign pulse_e = pulse_c & ~pulse_d;
    assign cyc     = |pulse_e;

    //------------------------------------------------------------
    // overload: out of regulation for too many cycles
    //------------------------------------------------------------
    logic [5:0]       uv_cnt [N_OUT];
    logic [N_OUT-1:0] uv_ovl;

    // per-output count of switching cycles spent below the window
    always_ff @(posedge mclk_in or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < N_OUT; i++) uv_cnt[i] <= 6'h00;
        end else if (ce_in) begin
            for (int i = 0; i < N_OUT; i++) begin
                if (clr || !uv_c[i])
                    uv_cnt[i] <= 6'h00;
                else if (cyc && uv_cnt[i] <= UV_CYCLES)
                    uv_cnt[i] <= uv_cnt[i] + 6'h01;
            end
        end
    end

    always_comb begin
        for (int i = 0; i < N_OUT; i++)
            uv_ovl[i] = uv_cnt[i] > UV_CYCLES;
    end

    //------------------------------------------------------------
    // average pulse rate limit
    //------------------------------------------------------------
    logic [7:0]       lim [N_OUT];
    logic [13:0]      win_cnt;
    logic             win_end;
    logic [7:0]       pcnt [N_OUT];
    logic [3:0]       qcnt [N_OUT];
    logic [N_OUT-1:0] lim_hit;

    // limit codes: pin a resistor code for first output, pin b resistor code for rail, caps for second
    assign lim[0] = lim_count(res_a, WIN_CYCLES);
    assign lim[1] = lim_count({cap_b, cap_a}, WIN_CYCLES);
    assign lim[2] = lim_count(res_b, WIN_CYCLES);
    assign win_end = win_cnt == 14'(WIN_CYCLES - 1);

    // free-running averaging window
    always_ff @(posedge mclk_in or negedge rst_n) begin
        if (!rst_n)       win_cnt <= 14'h0000;
        else if (ce_in)   win_cnt <= win_end ? 14'h0000 : win_cnt + 14'h0001;
    end

    // pulses per window, then consecutive windows above the limit
    always_ff @(posedge mclk_in or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < N_OUT; i++) begin
                pcnt[i] <= 8'h00;
                qcnt[i] <= 4'h0;
            end
        end else if (ce_in) begin
            for (int i = 0; i < N_OUT; i++) begin
                if (clr) begin
                    pcnt[i] <= 8'h00;
                    qcnt[i] <= 4'h0;
                end else if (win_end) begin
                    pcnt[i] <= {7'h00, pulse_e[i]};
                    if (pcnt[i] <= lim[i])
                        qcnt[i] <= 4'h0;
                    else if (qcnt[i] < QUAL_WINS)
                        qcnt[i] <= qcnt[i] + 4'h1;
                end else if (pulse_e[i] && pcnt[i] != 8'hff) begin
                    pcnt[i] <= pcnt[i] + 8'h01;
                end
            end
        end
    end

    always_comb begin
        for (int i = 0; i < N_OUT; i++)
            lim_hit[i] = qcnt[i] == QUAL_WINS;
    end

    //------------------------------------------------------------
    // fault events and response
    //------------------------------------------------------------
    logic f_uv;
    logic f_lim;
    logic f_ov;
    logic f_gnd;
    logic to_latch;
    logic to_restart;

    assign f_uv   = run && en && |uv_ovl;
    assign f_lim  = run && en && |lim_hit;
    assign f_ov   = run && en && |ov_c;
    assign f_gnd  = run && en && |ret_c;
    assign ev     = {t_sd, thermal_protect_level && !hot,
                     run && en && |(asym_c | open_c | short_c | ret_c),
                     f_ov, f_lim || f_gnd, f_uv};

    // one response per fault; latch choice is a fixed strap for overload, rate and ov; shutdown always latches, return short restarts
    assign to_latch   = t_sd || (f_uv && lsel[0]) || (f_lim && lsel[1]) ||
                        (f_ov && lsel[2]);
    assign to_restart = f_uv || f_lim || f_ov || f_gnd;

    logic [31:0] rs_cnt;

    // fault response selection
    always_comb begin
        next_state = state;
        unique case (state)
            ST_RUN:     if (to_latch) next_state = ST_LATCH;
                        else if (to_restart) next_state = ST_RESTART;
            ST_RESTART: if (t_sd) next_state = ST_LATCH;
                        else if (rs_cnt == 32'(RESTART_CYCLES - 1))
                            next_state = ST_RUN;
            ST_LATCH:   next_state = ST_LATCH;
        endcase
    end

    // state and silence timer while the primary times out
    always_ff @(posedge mclk_in or negedge rst_n) begin
        if (!rst_n) begin
            state  <= ST_RUN;
            rs_cnt <= 32'h0000_0000;
        end else if (ce_in) begin
            state  <= next_state;
            rs_cnt <= (state == ST_RESTART) ? rs_cnt + 32'h0000_0001
                                            : 32'h0000_0000;
        end
    end

    //------------------------------------------------------------
    // thermal hold
    //------------------------------------------------------------
    // hysteretic: set above protect level, cleared below it minus hysteresis
    always_ff @(posedge mclk_in or negedge rst_n) begin
        if (!rst_n)                   hot <= 1'b0;
        else if (ce_in && thermal_protect_level)     hot <= 1'b1;
        else if (ce_in && t_cool)     hot <= 1'b0;
    end

    //------------------------------------------------------------
    // string disables
    //------------------------------------------------------------
    logic [N_STR-1:0] gnd_pend;

    // faulty strings go off at once; a grounded return waits for restart
    always_ff @(posedge mclk_in or negedge rst_n) begin
        if (!rst_n) begin
            string_off_out <= '0;
            gnd_pend       <= '0;
        end else if (ce_in) begin
            if (run && en)
                string_off_out <= string_off_out | asym_c |
                                  open_c | short_c;
            if (f_gnd)
                gnd_pend <= gnd_pend | ret_c;
            if (state == ST_RESTART && next_state == ST_RUN) begin
                string_off_out <= string_off_out | gnd_pend;
                gnd_pend       <= '0;
            end
        end
    end

    //------------------------------------------------------------
    // link outputs
    //------------------------------------------------------------
    // requests only while running; latch request held until power cycle
    always_ff @(posedge mclk_in or negedge rst_n) begin
        if (!rst_n) begin
            req_enable_out  <= 1'b0;
            latch_off_out   <= 1'b0;
            outputs_off_out <= 1'b1;
            rail_hold_out   <= 1'b0;
        end else if (ce_in) begin
            req_enable_out  <= next_state == ST_RUN;
            latch_off_out   <= next_state == ST_LATCH;
            outputs_off_out <= next_state != ST_RUN || hot;
            rail_hold_out   <= hot && next_state == ST_RUN;
        end
    end

    //------------------------------------------------------------
    // register bus and interrupt
    //------------------------------------------------------------
    // hardware set beats a write-one clear in the same cycle
    always_comb begin
        next_status = status;
        if (wr_in && addr_in == A_STATUS)
            next_status = status & ~wdata_in[N_EV-1:0];
        next_status = next_status | ev;
    end

    // control, mask and sticky status
    always_ff @(posedge mclk_in or negedge rst_n) begin
        if (!rst_n) begin
            en     <= CTRL_RST;
            mask   <= MASK_RST;
            status <= '0;
            irq_out <= 1'b0;
        end else if (ce_in) begin
            if (wr_in && addr_in == A_CTRL) en   <= wdata_in[0];
            if (wr_in && addr_in == A_MASK) mask <= wdata_in[N_EV-1:0];
            status  <= next_status;
            irq_out <= |(next_status & mask);
        end
    end

    // read data one cycle after the strobe, zero otherwise
    always_ff @(posedge mclk_in or negedge rst_n) begin
        if (!rst_n) begin
            rdata_out <= 32'h0000_0000;
        end else if (ce_in) begin
            rdata_out <= 32'h0000_0000;
            if (rd_in) begin
                unique case (addr_in)
                    A_CTRL:   rdata_out <= {31'h0, en};
                    A_STATUS: rdata_out <= {26'h0, status};
                    A_MASK:   rdata_out <= {26'h0, mask};
                    A_STATE:  rdata_out <= {23'h0, hot, string_off_out,
                                            2'h0, state};
                    default:  rdata_out <= 32'h0000_0000;
                endcase
            end
        end
    end

    //------------------------------------------------------------
    // checks
    //------------------------------------------------------------
    AST_UV_LIMIT: assert property (@(posedge mclk_in) disable iff (!rst_n)
        $rose(uv_ovl[0]) |-> $past(uv_cnt[0]) == UV_CYCLES)
        else $error("overload not after 33 cycles");

    AST_UV_CLEAR: assert property (@(posedge mclk_in) disable iff (!rst_n)
        ce_in && !uv_c[1] |=> uv_cnt[1] == 6'h00)
        else $error("cycle count kept after recovery");

    AST_SD_LATCH: assert property (@(posedge mclk_in) disable iff (!rst_n)
        ce_in && t_sd |=> latch_off_out && !req_enable_out)
        else $error("no latch-off after shutdown level");

    AST_RESTART_QUIET: assert property (@(posedge mclk_in) disable iff (!rst_n)
        ce_in && state == ST_RUN && to_restart && !to_latch
        |=> !req_enable_out [*2])
        else $error("requests during auto-restart");

    AST_LATCH_HOLD: assert property (@(posedge mclk_in) disable iff (!rst_n)
        latch_off_out |=> latch_off_out)
        else $error("latch-off request dropped");

    AST_ONE_RESPONSE: assert property (@(posedge mclk_in) disable iff (!rst_n)
        !(latch_off_out && req_enable_out))
        else $error("both responses at once");

    AST_THERMAL: assert property (@(posedge mclk_in) disable iff (!rst_n)
        ce_in && hot && state == ST_RUN |=> outputs_off_out && rail_hold_out)
        else $error("thermal hold not applied");

    AST_RATE_QUAL: assert property (@(posedge mclk_in) disable iff (!rst_n)
        $rose(lim_hit[2]) |-> $past(pcnt[2]) > lim[2] && $past(win_end))
        else $error("rate fault without window over limit");

    AST_STRING_OFF: assert property (@(posedge mclk_in) disable iff (!rst_n)
        ce_in && run && en && (open_c[0] || short_c[0]) |=> string_off_out[0])
        else $error("faulty string left on");

endmodule : output_fault_supervisor

// [dv/primary_model.sv]
// model of the primary switch controller fed by the supervisor
`timescale 1ns/100ps
module primary_model (
    input  wire logic       mclk_in,
    input  wire logic       nrst_in,
    input  wire logic       req_in,
    input  wire logic       latch_in,
    input  wire logic [1:0] sel_in,
    input  wire logic [9:0] per_in,
    output logic      [2:0] pulse_out
);
    logic       latched;
    logic [9:0] cnt;
    // latch-off holds until mains is cycled, seen here as reset
    always_ff @(posedge mclk_in or negedge nrst_in) begin
        if (!nrst_in)
            latched <= 1'b0;
        else if (latch_in)
            latched <= 1'b1;
    end
    // two-cycle pulse each period, as the pin filter drops shorter ones;
    // none while requests stop or while latched
    always_ff @(posedge mclk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            cnt <= '0;
            pulse_out <= '0;
        end else begin
            cnt <= (cnt + 10'h1 >= per_in) ? '0 : cnt + 10'h1;
            pulse_out <= '0;
            if (req_in && !latched && per_in != '0 && cnt < 10'h2)
                pulse_out[sel_in] <= 1'b1;
        end
    end
endmodule : primary_model

// [dv/output_fault_supervisor_tb_top.sv]
// self-checking bench of the output fault supervisor
`timescale 1ns/100ps
module output_fault_supervisor_tb_top;
    import supervisor_pkg::*;
    localparam int WIN = 1000;
    localparam int RST = 20;
    logic        mclk_in = 1'b0, nrst_in = 1'b0, ce_in = 1'b1, wr_in = 1'b0, rd_in = 1'b0;
    logic        temp_prot_in = 1'b0, temp_cool_in = 1'b1, temp_sd_in = 1'b0;
    logic        limit_select_pin_a_cap_in = 1'b0, limit_select_pin_b_cap_in = 1'b0;
    logic [1:0]  limit_select_pin_a_res_in = '0, limit_select_pin_b_res_in = '0, psel = '0;
    logic [2:0]  uv_in = '0, ov_in = '0, latch_sel_in = '0, pulse_in;
    logic [3:0]  str_open_in = '0, str_short_in = '0, str_asym_in = '0, ret_gnd_in = '0;
    logic [3:0]  string_off_out;
    logic [7:0]  addr_in = '0;
    logic [9:0]  per = '0;
    logic [31:0] wdata_in = '0, rdata_out, d, e, seed = 32'h17;
    logic        req_enable_out, latch_off_out, outputs_off_out, rail_hold_out, irq_out;
    int          error_cnt = 0, checked = 0, n, lim;

    output_fault_supervisor #(.WIN_CYCLES(WIN), .RESTART_CYCLES(RST)) dut (
        .mclk_in, .nrst_in, .ce_in, .addr_in, .wdata_in, .wr_in, .rd_in, .rdata_out,
        .uv_in, .ov_in, .pulse_in, .str_open_in, .str_short_in, .str_asym_in, .ret_gnd_in,
        .temp_prot_in, .temp_cool_in, .temp_sd_in, .limit_select_pin_a_res_in,
        .limit_select_pin_b_res_in, .limit_select_pin_a_cap_in, .limit_select_pin_b_cap_in,
        .latch_sel_in, .req_enable_out, .latch_off_out, .string_off_out, .outputs_off_out,
        .rail_hold_out, .irq_out);
    primary_model pm (.mclk_in, .nrst_in, .req_in(req_enable_out), .latch_in(latch_off_out),
        .sel_in(psel), .per_in(per), .pulse_out(pulse_in));

    // clock, 100 ns period
    always #50 mclk_in = ~mclk_in;

    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : xs
    // pulses allowed in one window for a limit code
    function automatic int limf(input int k);
        int f[4] = '{LIM_KHZ0, LIM_KHZ1, LIM_KHZ2, LIM_KHZ3};
        return f[k] * WIN / CLK_KHZ;
    endfunction : limf
    task automatic chk(input logic [31:0] g, input logic [31:0] x);
        checked++;
        if (g !== x) begin
            error_cnt++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, g, x);
        end
    endtask : chk
    task automatic cyc(input int c);
        repeat (c) @(posedge mclk_in);
        #1;
    endtask : cyc
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
        @(posedge mclk_in);
        wr_in <= 1'b1;
        addr_in <= a;
        wdata_in <= v;
        @(posedge mclk_in);
        wr_in <= 1'b0;
        #1;
    endtask : wr_reg
    task automatic rd_reg(input logic [7:0] a, output logic [31:0] v);
        @(posedge mclk_in);
        rd_in <= 1'b1;
        addr_in <= a;
        @(posedge mclk_in);
        rd_in <= 1'b0;
        #1 v = rdata_out;
    endtask : rd_reg
    task automatic do_reset();
        @(posedge mclk_in);
        nrst_in <= 1'b0;
        per <= '0;
        cyc(16);
        @(posedge mclk_in);
        nrst_in <= 1'b1;
        cyc(4);
    endtask : do_reset
    // counts rising edges only, since each pulse stands for two cycles
    task automatic npulse(input int c);
        int         k;
        logic [2:0] p;
        k = 0;
        p = 3'h0;
        while (k < c) begin
            cyc(1);
            if (pulse_in !== 3'h0 && p === 3'h0)
                k++;
            p = pulse_in;
        end
    endtask : npulse
    task automatic conclude();
        $display("checks=%0d errors=%0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : conclude

    // watchdog against a hang
    initial begin
        #9000000;
        error_cnt++;
        conclude();
    end

    // main sequence
    initial begin
        do_reset();
        rd_reg(A_CTRL, d);
        chk(d, 32'(CTRL_RST));
        rd_reg(A_MASK, d);
        chk(d, 32'(MASK_RST));
        rd_reg(8'h10, d);
        chk(d, 32'h0);
        e = xs();
        wr_reg(A_MASK, e);
        rd_reg(A_MASK, d);
        chk(d, e & 32'h3f);
        wr_reg(A_MASK, 32'h0);
        chk({req_enable_out, latch_off_out, outputs_off_out, rail_hold_out, irq_out,
             string_off_out}, 9'h100);
        // overload: 32 low cycles pass, the 33rd restarts
        @(posedge mclk_in);
        per <= 10'd10;
        npulse(1);
        @(posedge mclk_in);
        uv_in <= 3'h1;
        npulse(32);
        cyc(6);
        chk(req_enable_out, 1'b1);
        npulse(1);
        @(posedge mclk_in);
        uv_in <= 3'h0;
        for (int i = 0; i < 12 && req_enable_out !== 1'b0; i++)
            cyc(1);
        n = 0;
        while (req_enable_out !== 1'b1 && n < 200) begin
            cyc(1);
            n++;
        end
        chk(n, RST);
        chk(latch_off_out, 1'b0);
        rd_reg(A_STATUS, d);
        chk(d, 32'h1 << S_UV);
        chk(irq_out, 1'b0);
        wr_reg(A_MASK, 32'h1 << S_UV);
        cyc(1);
        chk(irq_out, 1'b1);
        wr_reg(A_STATUS, 32'h1 << S_UV);
        chk(irq_out, 1'b0);
        // a return to regulation restarts the low-cycle count
        n = 5 + int'(xs() % 20);
        @(posedge mclk_in);
        uv_in <= 3'h4;
        npulse(n);
        @(posedge mclk_in);
        uv_in <= 3'h0;
        cyc(6);
        @(posedge mclk_in);
        uv_in <= 3'h4;
        npulse(30);
        cyc(6);
        chk(req_enable_out, 1'b1);
        @(posedge mclk_in);
        uv_in <= 3'h0;
        // overvoltage on each output, latch only where selected
        for (int i = 0; i < 3; i++) begin
            d = xs();
            @(posedge mclk_in);
            latch_sel_in <= {i == 2, d[1:0]};
            do_reset();
            @(posedge mclk_in);
            ov_in <= 3'(1 << i);
            cyc(6);
            chk(req_enable_out, 1'b0);
            chk(latch_off_out, i == 2);
            @(posedge mclk_in);
            ov_in <= 3'h0;
            cyc(40);
            chk(req_enable_out, i != 2);
        end
        // rate limit per code: three runs above the limit, one at it
        for (int k = 0; k < 4; k++) begin
            d = xs();
            @(posedge mclk_in);
            limit_select_pin_a_res_in <= (k == 0) ? 2'h0 : d[1:0];
            limit_select_pin_b_res_in <= (k == 2) ? 2'h2 : d[3:2];
            limit_select_pin_a_cap_in <= k == 1 || k == 3 || d[4];
            limit_select_pin_b_cap_in <= k == 3 || (k != 1 && d[5]);
            latch_sel_in <= d[8:6];
            do_reset();
            lim = limf(k);
            @(posedge mclk_in);
            psel <= (k == 3) ? 2'h1 : 2'(k);
            per <= (k == 3) ? 10'(WIN / lim + 1) : 10'(WIN / (lim + 1));
            cyc(9000);
            rd_reg(A_STATUS, d);
            chk(d, 32'h0);
            cyc(3200);
            rd_reg(A_STATUS, d);
            chk(d[S_LIM], k != 3);
        end
        // string faults, then a return short to ground
        do_reset();
        @(posedge mclk_in);
        str_open_in <= 4'h1;
        str_short_in <= 4'h2;
        str_asym_in <= 4'h4;
        cyc(6);
        chk({string_off_out, req_enable_out}, 5'h0f);
        @(posedge mclk_in);
        ret_gnd_in <= 4'h8;
        cyc(6);
        chk({string_off_out, req_enable_out}, 5'h0e);
        @(posedge mclk_in);
        ret_gnd_in <= 4'h0;
        cyc(30);
        chk({string_off_out, req_enable_out, latch_off_out}, 6'h3e);
        // thermal hold with hysteresis, then shutdown level
        do_reset();
        @(posedge mclk_in);
        temp_prot_in <= 1'b1;
        temp_cool_in <= 1'b0;
        cyc(6);
        chk({outputs_off_out, rail_hold_out, req_enable_out}, 3'h7);
        @(posedge mclk_in);
        temp_prot_in <= 1'b0;
        cyc(6);
        chk({outputs_off_out, rail_hold_out}, 2'h3);
        @(posedge mclk_in);
        temp_cool_in <= 1'b1;
        cyc(6);
        chk({outputs_off_out, rail_hold_out}, 2'h0);
        @(posedge mclk_in);
        latch_sel_in <= 3'h0;
        temp_sd_in <= 1'b1;
        cyc(6);
        chk({latch_off_out, req_enable_out}, 2'h2);
        rd_reg(A_STATE, d);
        chk(d[1:0], 2'h2);
        conclude();
    end
endmodule : output_fault_supervisor_tb_top
